// File: design/awd_top.sv
// Purpose: Converter result registers with programmable window detector
// Assumes: Byte register port with read and write strobes on the system clock
// Notes: Sample code and start pin come from outside and are synchronised
`timescale 1ns/1ps
`default_nettype none
module awd_top
(
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic [3:0] TIMER_OVF_I,
  input wire logic CONV_START_PIN_I,
  input wire logic [9:0] SAMPLE_CODE_I,
  output logic [7:0] SFR_RDATA_O,
  output logic WINDOW_FLAG_O,
  output logic CONV_DONE_FLAG_O
);
  // ==========================================================================
  // Helpers
  // Place a 10-bit code in the 16-bit register pair
  function automatic logic [15:0] place_code(input logic [9:0] code, input logic left,
                                             input logic diff);
    logic [15:0] word;
    word = 16'h0000;
    if (left)
      word = {code, {awd_pkg::RES_PAD{1'b0}}};
    else if (diff)
      word = {{awd_pkg::RES_PAD{code[9]}}, code};
    else
      word = {{awd_pkg::RES_PAD{1'b0}}, code};
    return word;
  endfunction

  // Strict less-than, signed or unsigned
  function automatic logic less(input logic [15:0] a, input logic [15:0] b, input logic sgn);
    logic res;
    res = sgn ? ($signed(a) < $signed(b)) : (a < b);
    return res;
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic [9:0] sample_s1_r, sample_s2_r;
  logic pin_s1_r, pin_s2_r, pin_d_r;

  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      sample_s1_r <= 10'h000;
      sample_s2_r <= 10'h000;
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r <= 1'b0;
    end
    else
    begin
      sample_s1_r <= SAMPLE_CODE_I;
      sample_s2_r <= sample_s1_r;
      pin_s1_r <= CONV_START_PIN_I;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  // ==========================================================================
  // Register state
  logic [7:0] lt_low_r, lt_low_nxt, lt_high_r, lt_high_nxt;
  logic [7:0] gt_low_r, gt_low_nxt, gt_high_r, gt_high_nxt;
  logic [7:0] res_low_r, res_low_nxt, res_high_r, res_high_nxt;
  logic [7:0] config_r, config_nxt;
  logic [4:0] neg_sel_r, neg_sel_nxt;
  logic enable_r, enable_nxt, track_mode_r, track_mode_nxt;
  logic done_flag_r, done_flag_nxt, win_flag_r, win_flag_nxt;
  logic [2:0] soc_r, soc_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  logic seq_busy, seq_done, start_conv, trig, wr_cn, diff_mode, left_just, hit;
  logic [9:0] seq_code;
  logic [15:0] res_word, lt_word, gt_word;

  assign wr_cn = SFR_WR_I && (SFR_ADDR_I == awd_pkg::ADDR_CONTROL);
  assign diff_mode = (neg_sel_r != awd_pkg::NEG_SEL_GROUND);
  assign left_just = config_r[awd_pkg::CF_JUSTIFY_BIT];

  // Start source selection
  always_comb
  begin
    case (soc_r)
      awd_pkg::SOC_WRITE: trig = wr_cn && SFR_WDATA_I[awd_pkg::CN_BUSY_BIT];
      awd_pkg::SOC_TIMER0: trig = TIMER_OVF_I[0];
      awd_pkg::SOC_TIMER2: trig = TIMER_OVF_I[2];
      awd_pkg::SOC_TIMER1: trig = TIMER_OVF_I[1];
      awd_pkg::SOC_PIN: trig = pin_s2_r && !pin_d_r;
      awd_pkg::SOC_TIMER3: trig = TIMER_OVF_I[3];
      default: trig = 1'b0;
    endcase
  end
  assign start_conv = enable_r && trig && !seq_busy;

  // ==========================================================================
  // Conversion sequencer
  awd_sar_seq u_seq
  (
    .clk_i(CLK_I),
    .reset_n_i(RESET_N_I),
    .start_i(start_conv),
    .div_i(config_r[7:awd_pkg::CF_DIV_LSB]),
    .code_i(sample_s2_r),
    .busy_o(seq_busy),
    .done_o(seq_done),
    .code_o(seq_code)
  );

  // ==========================================================================
  // Window compare on the freshly formatted result
  assign res_word = place_code(seq_code, left_just, diff_mode);
  assign lt_word = {lt_high_r, lt_low_r};
  assign gt_word = {gt_high_r, gt_low_r};

  always_comb
  begin
    if (less(gt_word, lt_word, diff_mode))
      hit = less(gt_word, res_word, diff_mode) && less(res_word, lt_word, diff_mode);
    else
      hit = less(res_word, lt_word, diff_mode) || less(gt_word, res_word, diff_mode);
  end

  // Register writes, result load and sticky flags
  always_comb
  begin
    lt_low_nxt = lt_low_r;
    lt_high_nxt = lt_high_r;
    gt_low_nxt = gt_low_r;
    gt_high_nxt = gt_high_r;
    res_low_nxt = res_low_r;
    res_high_nxt = res_high_r;
    config_nxt = config_r;
    neg_sel_nxt = neg_sel_r;
    enable_nxt = enable_r;
    track_mode_nxt = track_mode_r;
    done_flag_nxt = done_flag_r;
    win_flag_nxt = win_flag_r;
    soc_nxt = soc_r;
    if (SFR_WR_I)
    begin
      case (SFR_ADDR_I)
        awd_pkg::ADDR_LT_LOW: lt_low_nxt = SFR_WDATA_I;
        awd_pkg::ADDR_LT_HIGH: lt_high_nxt = SFR_WDATA_I;
        awd_pkg::ADDR_GT_LOW: gt_low_nxt = SFR_WDATA_I;
        awd_pkg::ADDR_GT_HIGH: gt_high_nxt = SFR_WDATA_I;
        awd_pkg::ADDR_RES_LOW: res_low_nxt = SFR_WDATA_I;
        awd_pkg::ADDR_RES_HIGH: res_high_nxt = SFR_WDATA_I;
        awd_pkg::ADDR_CONFIG: config_nxt = {SFR_WDATA_I[7:2], 2'b00};
        awd_pkg::ADDR_AMUX_NEG: neg_sel_nxt = SFR_WDATA_I[4:0];
        awd_pkg::ADDR_CONTROL:
        begin
          enable_nxt = SFR_WDATA_I[awd_pkg::CN_EN_BIT];
          track_mode_nxt = SFR_WDATA_I[awd_pkg::CN_TM_BIT];
          done_flag_nxt = SFR_WDATA_I[awd_pkg::CN_INT_BIT];
          win_flag_nxt = SFR_WDATA_I[awd_pkg::CN_WINT_BIT];
          soc_nxt = SFR_WDATA_I[2:0];
        end
        default:
        begin
          soc_nxt = soc_r;
        end
      endcase
    end
    // Completion loads result and beats a same-cycle software clear
    if (seq_done)
    begin
      {res_high_nxt, res_low_nxt} = res_word;
      done_flag_nxt = 1'b1;
      if (hit)
        win_flag_nxt = 1'b1;
    end
  end

  // Read data mux, registered on the read strobe
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (SFR_RD_I)
    begin
      case (SFR_ADDR_I)
        awd_pkg::ADDR_LT_LOW: rdata_nxt = lt_low_r;
        awd_pkg::ADDR_LT_HIGH: rdata_nxt = lt_high_r;
        awd_pkg::ADDR_GT_LOW: rdata_nxt = gt_low_r;
        awd_pkg::ADDR_GT_HIGH: rdata_nxt = gt_high_r;
        awd_pkg::ADDR_RES_LOW: rdata_nxt = res_low_r;
        awd_pkg::ADDR_RES_HIGH: rdata_nxt = res_high_r;
        awd_pkg::ADDR_CONFIG: rdata_nxt = config_r;
        awd_pkg::ADDR_AMUX_NEG: rdata_nxt = {3'h0, neg_sel_r};
        awd_pkg::ADDR_CONTROL: rdata_nxt = {enable_r, track_mode_r, done_flag_r, seq_busy,
                                           win_flag_r, soc_r};
        default: rdata_nxt = awd_pkg::RST_ZERO;
      endcase
    end
  end

  // Register bank
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      lt_low_r <= awd_pkg::RST_LIMIT_LT;
      lt_high_r <= awd_pkg::RST_LIMIT_LT;
      gt_low_r <= awd_pkg::RST_LIMIT_GT;
      gt_high_r <= awd_pkg::RST_LIMIT_GT;
      res_low_r <= awd_pkg::RST_ZERO;
      res_high_r <= awd_pkg::RST_ZERO;
      config_r <= awd_pkg::RST_CONFIG;
      neg_sel_r <= 5'h00;
      enable_r <= 1'b0;
      track_mode_r <= 1'b0;
      done_flag_r <= 1'b0;
      win_flag_r <= 1'b0;
      soc_r <= awd_pkg::SOC_WRITE;
      rdata_r <= awd_pkg::RST_ZERO;
    end
    else
    begin
      lt_low_r <= lt_low_nxt;
      lt_high_r <= lt_high_nxt;
      gt_low_r <= gt_low_nxt;
      gt_high_r <= gt_high_nxt;
      res_low_r <= res_low_nxt;
      res_high_r <= res_high_nxt;
      config_r <= config_nxt;
      neg_sel_r <= neg_sel_nxt;
      enable_r <= enable_nxt;
      track_mode_r <= track_mode_nxt;
      done_flag_r <= done_flag_nxt;
      win_flag_r <= win_flag_nxt;
      soc_r <= soc_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign SFR_RDATA_O = rdata_r;
  assign WINDOW_FLAG_O = win_flag_r;
  assign CONV_DONE_FLAG_O = done_flag_r;
endmodule
`default_nettype wire

// File: design/awd_pkg.sv
// Purpose: Shared constants for the converter window detector block
// Assumes: Byte-wide special-function-register port, 10 MHz system clock
// Notes: Addresses and timing counts live here; bit positions and reset values mostly do, but some are literals in the other files
package awd_pkg;
  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_AMUX_NEG = 8'hba;
  localparam logic [7:0] ADDR_CONFIG = 8'hbc;
  localparam logic [7:0] ADDR_RES_LOW = 8'hbd;
  localparam logic [7:0] ADDR_RES_HIGH = 8'hbe;
  localparam logic [7:0] ADDR_GT_HIGH = 8'hc3;
  localparam logic [7:0] ADDR_GT_LOW = 8'hc4;
  localparam logic [7:0] ADDR_LT_LOW = 8'hc5;
  localparam logic [7:0] ADDR_LT_HIGH = 8'hc6;
  localparam logic [7:0] ADDR_CONTROL = 8'he8;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_LIMIT_LT = 8'h00;
  localparam logic [7:0] RST_LIMIT_GT = 8'hff;
  localparam logic [7:0] RST_CONFIG = 8'hf8;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int CN_EN_BIT = 7;
  localparam int CN_TM_BIT = 6;
  localparam int CN_INT_BIT = 5;
  localparam int CN_BUSY_BIT = 4;
  localparam int CN_WINT_BIT = 3;
  localparam int CF_JUSTIFY_BIT = 2;
  localparam int CF_DIV_LSB = 3;
  localparam int RES_PAD = 6;
  localparam logic [4:0] NEG_SEL_GROUND = 5'h1f;

  // ==========================================================================
  // Start-of-conversion source codes
  localparam logic [2:0] SOC_WRITE = 3'h0;
  localparam logic [2:0] SOC_TIMER0 = 3'h1;
  localparam logic [2:0] SOC_TIMER2 = 3'h2;
  localparam logic [2:0] SOC_TIMER1 = 3'h3;
  localparam logic [2:0] SOC_PIN = 3'h4;
  localparam logic [2:0] SOC_TIMER3 = 3'h5;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TRACK_MIN_NS = 300;
  localparam int TRACK_CYC_RAW = (TRACK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRACK_CYC = (TRACK_CYC_RAW < 1) ? 1 : TRACK_CYC_RAW;
  localparam int CONV_SAR_TICKS = 10;
endpackage

// File: design/awd_sar_seq.sv
// Purpose: Conversion sequencer with SAR clock enable divider
// Assumes: Sample code already synchronised to the system clock
// Notes: Result is delivered after tracking plus the set number of SAR ticks
`timescale 1ns/1ps
`default_nettype none
module awd_sar_seq
#(
  parameter int CONV_TICKS = awd_pkg::CONV_SAR_TICKS,
  parameter int TRACK_CYCLES = awd_pkg::TRACK_CYC
)
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic [4:0] div_i,
  input wire logic [9:0] code_i,
  output logic busy_o,
  output logic done_o,
  output logic [9:0] code_o
);
  if (CONV_TICKS < awd_pkg::CONV_SAR_TICKS || CONV_TICKS > 15 || TRACK_CYCLES < 1
      || TRACK_CYCLES > 15)
  begin : g_bad_param
    $error("awd_sar_seq: unsupported tick or track count");
  end

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_TRACK = 2'b01,
    SEQ_CONV = 2'b10
  } awd_seq_e;

  localparam logic [3:0] TICKS_LAST = 4'(CONV_TICKS - 1);
  localparam logic [3:0] TRACK_LAST = 4'(TRACK_CYCLES - 1);

  awd_seq_e state_r, state_nxt;
  logic [4:0] div_cnt_r, div_cnt_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [9:0] code_r, code_nxt;
  logic done_r, done_nxt;
  logic sar_tick;

  // ==========================================================================
  // SAR clock enable: one pulse every div_i+1 system clocks
  assign sar_tick = (div_cnt_r == div_i);

  // Next-state logic for tracking and conversion
  always_comb
  begin
    state_nxt = state_r;
    div_cnt_nxt = sar_tick ? 5'h00 : 5'(div_cnt_r + 5'h01);
    cnt_nxt = cnt_r;
    code_nxt = code_r;
    done_nxt = 1'b0;
    case (state_r)
      SEQ_IDLE:
      begin
        div_cnt_nxt = 5'h00;
        if (start_i)
        begin
          state_nxt = SEQ_TRACK;
          cnt_nxt = 4'h0;
        end
      end
      SEQ_TRACK:
      begin
        div_cnt_nxt = 5'h00;
        cnt_nxt = 4'(cnt_r + 4'h1);
        if (cnt_r == TRACK_LAST)
        begin
          state_nxt = SEQ_CONV;
          cnt_nxt = 4'h0;
          code_nxt = code_i; // Hold taken at end of tracking
        end
      end
      SEQ_CONV:
      begin
        if (sar_tick)
        begin
          cnt_nxt = 4'(cnt_r + 4'h1);
          if (cnt_r == TICKS_LAST)
          begin
            state_nxt = SEQ_IDLE;
            done_nxt = 1'b1;
          end
        end
      end
      default:
      begin
        state_nxt = SEQ_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_r <= SEQ_IDLE;
      div_cnt_r <= 5'h00;
      cnt_r <= 4'h0;
      code_r <= 10'h000;
      done_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      div_cnt_r <= div_cnt_nxt;
      cnt_r <= cnt_nxt;
      code_r <= code_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy_o = (state_r != SEQ_IDLE);
  assign done_o = done_r;
  assign code_o = code_r;
endmodule
`default_nettype wire

// File: testbench/awd_window_asserts.sv
// Purpose: Port checker for the window detector block
// Assumes: Bound to awd_top, one clock domain
// Notes: Keeps shadows of the less-than low byte and of the stored enable bit
`timescale 1ns/1ps
`default_nettype none
module awd_window_asserts
(
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic WINDOW_FLAG_O,
  input wire logic CONV_DONE_FLAG_O
);
  // ==========
  // Helper state
  logic [7:0] lt_low_r;
  logic [7:0] lt_low_nxt;
  logic ctl_wr;
  logic start_wr;
  logic en_r;
  logic en_nxt;
  // Control writes, and those that start a conversion; the stored enable gates a start
  assign ctl_wr = SFR_WR_I && (SFR_ADDR_I == awd_pkg::ADDR_CONTROL);
  assign start_wr = ctl_wr && en_r && SFR_WDATA_I[4] && !SFR_WDATA_I[5]
    && (SFR_WDATA_I[2:0] == 3'h0);
  // Next value of the shadow byte and of the enable bit
  always_comb
  begin
    lt_low_nxt = lt_low_r;
    en_nxt = en_r;
    if (SFR_WR_I && (SFR_ADDR_I == awd_pkg::ADDR_LT_LOW))
    begin
      lt_low_nxt = SFR_WDATA_I;
    end
    if (ctl_wr)
    begin
      en_nxt = SFR_WDATA_I[7];
    end
  end
  // Shadow registers
  always_ff @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      lt_low_r <= 8'h00;
      en_r <= 1'b0;
    end
    else
    begin
      lt_low_r <= lt_low_nxt;
      en_r <= en_nxt;
    end
  end
  // ==========
  // Assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  lt_low_read_a: assert property (
    SFR_RD_I && (SFR_ADDR_I == awd_pkg::ADDR_LT_LOW) |=> SFR_RDATA_O == $past(lt_low_r))
    else $error("less-than low byte reads wrong");
  rdata_hold_a: assert property (
    !SFR_RD_I |=> $stable(SFR_RDATA_O))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (
    SFR_RD_I && (SFR_ADDR_I == 8'h00) |=> SFR_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  cfg_pad_a: assert property (
    SFR_RD_I && (SFR_ADDR_I == awd_pkg::ADDR_CONFIG) |=> SFR_RDATA_O[1:0] == 2'h0)
    else $error("config unused bits not zero");
  wflag_cause_a: assert property ($rose(WINDOW_FLAG_O) |-> CONV_DONE_FLAG_O)
    else $error("window flag set without a completion");
  wflag_stick_a: assert property (WINDOW_FLAG_O && !ctl_wr |=> WINDOW_FLAG_O)
    else $error("window flag dropped by itself");
  done_stick_a: assert property (
    CONV_DONE_FLAG_O && !ctl_wr |=> CONV_DONE_FLAG_O)
    else $error("done flag dropped by itself");
  wflag_clear_a: assert property (
    ctl_wr && !SFR_WDATA_I[5] && !SFR_WDATA_I[3] |=> !WINDOW_FLAG_O || CONV_DONE_FLAG_O)
    else $error("window flag not cleared");
  conv_time_a: assert property (
    start_wr |=> (!CONV_DONE_FLAG_O)[*8] ##1 (!CONV_DONE_FLAG_O)[*2] ##[1:400] CONV_DONE_FLAG_O)
    else $error("conversion too short or too long");
  // Main scenarios
  cover property (start_wr);
  cover property ($rose(WINDOW_FLAG_O));
  cover property (WINDOW_FLAG_O ##1 !WINDOW_FLAG_O);
endmodule
bind awd_top awd_window_asserts i_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
  .SFR_ADDR_I(SFR_ADDR_I), .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I),
  .SFR_WDATA_I(SFR_WDATA_I), .SFR_RDATA_O(SFR_RDATA_O), .WINDOW_FLAG_O(WINDOW_FLAG_O),
  .CONV_DONE_FLAG_O(CONV_DONE_FLAG_O));
`default_nettype wire

// File: testbench/adc_window_detector_test.sv
// Purpose: Self-checking bench for the window detector block
// Assumes: Divider set to zero so conversions are short
// Notes: Limits are programmed byte by byte before each check_win conversion
`timescale 1ns/1ps
`default_nettype none
module adc_window_detector_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [3:0] tovf = 4'h0;
  logic pin = 1'b0;
  logic [9:0] code = 10'h000;
  logic [7:0] rdata;
  logic wflag;
  logic done;
  logic [7:0] rv;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  // ==========
  // Clock and design
  always #50 clk = ~clk;
  awd_top i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .SFR_ADDR_I(addr), .SFR_WR_I(wr),
    .SFR_RD_I(rd), .SFR_WDATA_I(wdata), .TIMER_OVF_I(tovf), .CONV_START_PIN_I(pin),
    .SAMPLE_CODE_I(code), .SFR_RDATA_O(rdata), .WINDOW_FLAG_O(wflag),
    .CONV_DONE_FLAG_O(done));
  // ==========
  // Tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1;
    d = rdata;
  endtask
  task automatic run_conv(input logic [2:0] src, input logic [9:0] c);
    int n;
    @(posedge clk);
    code <= c;
    wr_reg(awd_pkg::ADDR_CONTROL, {1'b1, 2'b00, src == 3'h0, 1'b0, src});
    @(posedge clk);
    case (src)
      3'h1: tovf <= 4'h1;
      3'h2: tovf <= 4'h4;
      3'h3: tovf <= 4'h2;
      3'h4: pin <= 1'b1;
      3'h5: tovf <= 4'h8;
      default: tovf <= 4'h0;
    endcase
    @(posedge clk);
    tovf <= 4'h0;
    n = 0;
    while (done !== 1'b1 && n < 500)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    pin <= 1'b0;
    chk(8'(done), 8'h01);
  endtask
  task automatic check_win(input logic d, input logic [15:0] gt, input logic [15:0] lt,
    input logic [9:0] c, input logic e);
    logic [15:0] w;
    wr_reg(awd_pkg::ADDR_AMUX_NEG, d ? 8'h00 : 8'h1f);
    wr_reg(awd_pkg::ADDR_GT_HIGH, gt[15:8]);
    wr_reg(awd_pkg::ADDR_GT_LOW, gt[7:0]);
    wr_reg(awd_pkg::ADDR_LT_HIGH, lt[15:8]);
    wr_reg(awd_pkg::ADDR_LT_LOW, lt[7:0]);
    run_conv(3'h0, c);
    chk(8'(wflag), 8'(e));
    w = d ? {{6{c[9]}}, c} : {6'h00, c};
    rd_reg(awd_pkg::ADDR_RES_HIGH, rv);
    chk(rv, w[15:8]);
    rd_reg(awd_pkg::ADDR_RES_LOW, rv);
    chk(rv, w[7:0]);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      print_verdict;
    end
  end
  // ==========
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(awd_pkg::ADDR_LT_LOW, rv);
    chk(rv, 8'h00);
    wr_reg(awd_pkg::ADDR_LT_LOW, 8'ha5);
    rd_reg(awd_pkg::ADDR_LT_LOW, rv);
    chk(rv, 8'ha5);
    rd_reg(8'h00, rv);
    chk(rv, 8'h00);
    wr_reg(awd_pkg::ADDR_CONFIG, 8'h00);
    rd_reg(awd_pkg::ADDR_CONFIG, rv);
    chk(rv, 8'h00);
    // Enable is the stored bit, so it must be set before the first start write
    wr_reg(awd_pkg::ADDR_CONTROL, 8'h80);
    rd_reg(awd_pkg::ADDR_CONTROL, rv);
    chk(rv, 8'h80);
    $display("test registers done");
    check_win(1'b0, 16'h0040, 16'h0080, 10'h040, 1'b0);
    check_win(1'b0, 16'h0040, 16'h0080, 10'h041, 1'b1);
    check_win(1'b0, 16'h0040, 16'h0080, 10'h07f, 1'b1);
    check_win(1'b0, 16'h0040, 16'h0080, 10'h080, 1'b0);
    check_win(1'b0, 16'h0080, 16'h0040, 10'h03f, 1'b1);
    check_win(1'b0, 16'h0080, 16'h0040, 10'h040, 1'b0);
    check_win(1'b0, 16'h0080, 16'h0040, 10'h081, 1'b1);
    check_win(1'b0, 16'h0040, 16'h0040, 10'h040, 1'b0);
    check_win(1'b0, 16'h0100, 16'h03ff, 10'h200, 1'b1);
    repeat (6) @(posedge clk);
    #1;
    chk(8'(wflag), 8'h01);
    wr_reg(awd_pkg::ADDR_CONTROL, 8'h80);
    #1;
    chk(8'(wflag), 8'h00);
    $display("test single-ended done");
    check_win(1'b1, 16'hffff, 16'h0040, 10'h3ff, 1'b0);
    check_win(1'b1, 16'hffff, 16'h0040, 10'h000, 1'b1);
    check_win(1'b1, 16'hffff, 16'h0040, 10'h03f, 1'b1);
    check_win(1'b1, 16'hffff, 16'h0040, 10'h040, 1'b0);
    check_win(1'b1, 16'h0040, 16'hffff, 10'h3fe, 1'b1);
    check_win(1'b1, 16'h0040, 16'hffff, 10'h3ff, 1'b0);
    check_win(1'b1, 16'h0040, 16'hffff, 10'h041, 1'b1);
    check_win(1'b1, 16'h0100, 16'h03ff, 10'h200, 1'b0);
    $display("test differential done");
    wr_reg(awd_pkg::ADDR_CONFIG, 8'h04);
    run_conv(3'h0, 10'h3fe);
    rd_reg(awd_pkg::ADDR_RES_HIGH, rv);
    chk(rv, 8'hff);
    rd_reg(awd_pkg::ADDR_RES_LOW, rv);
    chk(rv, 8'h80);
    for (int s = 1; s < 6; s++)
    begin
      run_conv(3'(s), 10'h041);
    end
    $display("test justify and sources done");
    print_verdict;
  end
endmodule
`default_nettype wire
